/* inc/pmc_pkg.sv */
// Purpose: Constants, types and state layout of the power mode controller.
// Assumes: Byte-wide register port, one 100 MHz clock.
// Notes:   Shared by the controller and its wake source evaluator.
`default_nettype none

package pmc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEQ_W = 3;

  // Register addresses.
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] OSC_CTRL_ADDR = 8'hB2;
  localparam logic [7:0] REG_CTRL_ADDR = 8'hC9;
  localparam logic [7:0] STATUS_ADDR = 8'hE0;

  // Field positions.
  localparam int unsigned IDLE_BIT = 0;
  localparam int unsigned STOP_BIT = 1;
  localparam int unsigned GF_LSB = 2;
  localparam int unsigned SUSP_BIT = 5;
  localparam int unsigned REGOFF_BIT = 0;

  // Reset values and the fetch address after a reset.
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] BOOT_ADDR = 16'h0000;

  // Timing of the reset sequence.
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned RST_SEQ_NS = 50;
  localparam int unsigned RST_SEQ_CYC = (RST_SEQ_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [SEQ_W-1:0] SEQ_LAST = SEQ_W'(RST_SEQ_CYC - 1);

  typedef enum logic [2:0] {PMC_SEQ, PMC_RUN, PMC_IDLE, PMC_STOP, PMC_SUSP} pmc_mode_t;

  typedef struct packed {
    pmc_mode_t mode;
    logic [5:0] gf;
    logic idle_pend;
    logic stop_pend;
    logic susp_pend;
    logic reg_down;
    logic wake_pulse;
    logic [7:0] osc_bits;
    logic [7:0] regc_bits;
    logic [7:0] rdata;
    logic [SEQ_W-1:0] seq_cnt;
  } pmc_state_t;

  localparam pmc_state_t PMC_RST_VAL = '{mode: PMC_SEQ, gf: 6'h00, idle_pend: 1'b0,
    stop_pend: 1'b0, susp_pend: 1'b0, reg_down: 1'b0, wake_pulse: 1'b0, osc_bits: REG_RST,
    regc_bits: REG_RST, rdata: 8'h00, seq_cnt: SEQ_LAST};

endpackage : pmc_pkg

`default_nettype wire

/* inc/pmc_if.sv */
// Purpose: Carries mode and event signals between controller and wake evaluator.
// Assumes: Both ends on clk_sys.
// Notes:   Combinational decisions only.
`timescale 1ns/1ps
`default_nettype none

interface pmc_if;
  pmc_pkg::pmc_mode_t mode;
  logic reg_down;
  logic rst_pin;
  logic wdt_rst;
  logic mcd_rst;
  logic sw_rst;
  logic irq_pend;
  logic port_match;
  logic t3_ovf;
  logic t3_lowclk;
  logic usb_resume;
  logic rst_take;
  logic wake;

  modport ctl (output mode, reg_down, rst_pin, wdt_rst, mcd_rst, sw_rst, irq_pend,
    port_match, t3_ovf, t3_lowclk, usb_resume, input rst_take, wake);
  modport src (input mode, reg_down, rst_pin, wdt_rst, mcd_rst, sw_rst, irq_pend,
    port_match, t3_ovf, t3_lowclk, usb_resume, output rst_take, wake);
endinterface : pmc_if

`default_nettype wire

/* hw/pmc_wake.sv */
// Purpose: Decides which reset and wake events end the present power mode.
// Assumes: Event inputs are synchronous to clk_sys.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none

module pmc_wake (
  pmc_if.src ev
);

  logic int_rst;
  logic reg_gate;
  logic t3_wake;

  // ----------------------------------------------------------------
  // Reset acceptance
  // ----------------------------------------------------------------

  // Internal reset sources gathered.
  // watchdog ends idle
  assign int_rst = ev.wdt_rst | ev.mcd_rst | ev.sw_rst;

  assign reg_gate = (ev.mode == pmc_pkg::PMC_STOP) && ev.reg_down;

  // The pin always resets; internal sources only while the regulator is up.
  assign ev.rst_take = ev.rst_pin | (int_rst & ~reg_gate);

  // ----------------------------------------------------------------
  // Wake decisions
  // ----------------------------------------------------------------

  // Timer 3 only counts in suspend when it runs from a slow clock.
  assign t3_wake = ev.t3_ovf & ev.t3_lowclk;

  always_comb begin
    case (ev.mode)
      pmc_pkg::PMC_IDLE: ev.wake = ev.irq_pend;
      pmc_pkg::PMC_SUSP: ev.wake = ev.port_match | t3_wake | ev.usb_resume;
      default: ev.wake = 1'b0;
    endcase
  end

endmodule : pmc_wake

`default_nettype wire

/* hw/pmc_top.sv */
// Purpose: Power mode controller for idle, stop and suspend modes.
// Assumes: instr_done pulses at the end of each CPU instruction.
// Notes:   All state sits in one packed struct register.
`timescale 1ns/1ps
`default_nettype none

module pmc_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port.
  input wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmc_pkg::DATA_W-1:0] reg_rdata,
  // CPU side.
  input wire logic instr_done,
  input wire logic irq_pend,
  output logic cpu_halt,
  output logic cpu_rst,
  output logic [15:0] boot_addr,
  output logic wake_pulse,
  // Reset sources.
  input wire logic rst_pin,
  input wire logic wdt_rst,
  input wire logic mcd_rst,
  input wire logic sw_rst,
  // Suspend wake sources.
  input wire logic port_match,
  input wire logic t3_ovf,
  input wire logic t3_lowclk,
  input wire logic usb_resume,
  // Clock and power gates.
  output logic hfosc_en,
  output logic periph_clk_en,
  output logic usb_xcvr_en,
  output logic port_match_en,
  output logic t3_clk_en,
  output logic regulator_en
);

  pmc_pkg::pmc_state_t r;
  pmc_pkg::pmc_state_t n;
  logic [7:0] rd_val;
  logic wr_pwr;
  logic wr_osc;
  logic wr_regc;

  pmc_if ev ();

  // ----------------------------------------------------------------
  // Event evaluation
  // ----------------------------------------------------------------

  // Present mode and raw events go to the wake evaluator.
  assign ev.mode = r.mode;
  assign ev.reg_down = r.reg_down;
  assign ev.rst_pin = rst_pin;
  assign ev.wdt_rst = wdt_rst;
  assign ev.mcd_rst = mcd_rst;
  assign ev.sw_rst = sw_rst;
  assign ev.irq_pend = irq_pend;
  assign ev.port_match = port_match;
  assign ev.t3_ovf = t3_ovf;
  assign ev.t3_lowclk = t3_lowclk;
  assign ev.usb_resume = usb_resume;

  pmc_wake pmc_wake_i (
    .ev (ev.src)
  );

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------

  // Write decode of the three control registers.
  assign wr_pwr = reg_wr && (reg_addr == pmc_pkg::PWR_CTRL_ADDR);
  assign wr_osc = reg_wr && (reg_addr == pmc_pkg::OSC_CTRL_ADDR);
  assign wr_regc = reg_wr && (reg_addr == pmc_pkg::REG_CTRL_ADDR);

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rd_val = 8'h00;
    case (reg_addr)
      pmc_pkg::PWR_CTRL_ADDR: rd_val = {r.gf, 2'b00};
      pmc_pkg::OSC_CTRL_ADDR: begin
        rd_val = r.osc_bits;
        rd_val[pmc_pkg::SUSP_BIT] = r.susp_pend;
      end
      pmc_pkg::REG_CTRL_ADDR: rd_val = r.regc_bits;
      pmc_pkg::STATUS_ADDR: rd_val = {4'h0, r.reg_down, r.mode};
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Register writes, then the mode sequence, then reset override.
  always_comb begin
    n = r;
    n.wake_pulse = 1'b0;
    n.rdata = reg_rd ? rd_val : 8'h00;

    // Mode bits only arm a request; general flags store directly.
    if (wr_pwr) begin
      n.gf = reg_wdata[7:pmc_pkg::GF_LSB];
      if (reg_wdata[pmc_pkg::IDLE_BIT]) begin
        n.idle_pend = 1'b1;
      end
      if (reg_wdata[pmc_pkg::STOP_BIT]) begin
        n.stop_pend = 1'b1;
      end
    end
    if (wr_osc) begin
      n.osc_bits = reg_wdata;
      n.osc_bits[pmc_pkg::SUSP_BIT] = 1'b0;
      if (reg_wdata[pmc_pkg::SUSP_BIT]) begin
        n.susp_pend = 1'b1;
      end
    end
    if (wr_regc) begin
      n.regc_bits = reg_wdata;
    end

    case (r.mode)
      pmc_pkg::PMC_SEQ: begin
        if (r.seq_cnt == '0) begin
          n.mode = pmc_pkg::PMC_RUN;
        end else begin
          n.seq_cnt = r.seq_cnt - 1'b1;
        end
      end
      pmc_pkg::PMC_RUN: begin
        if (instr_done) begin
          if (n.stop_pend) begin
            n.mode = pmc_pkg::PMC_STOP;
            n.reg_down = n.regc_bits[pmc_pkg::REGOFF_BIT];
          end else if (n.idle_pend) begin
            n.mode = pmc_pkg::PMC_IDLE;
          end else if (n.susp_pend) begin
            n.mode = pmc_pkg::PMC_SUSP;
          end
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (ev.wake) begin
          n.mode = pmc_pkg::PMC_RUN;
          // A request written in the wake cycle survives the clear.
          n.idle_pend = wr_pwr && reg_wdata[pmc_pkg::IDLE_BIT];
          n.wake_pulse = 1'b1;
        end
      end
      pmc_pkg::PMC_SUSP: begin
        if (ev.wake) begin
          n.mode = pmc_pkg::PMC_RUN;
          // A request written in the wake cycle survives the clear.
          n.susp_pend = wr_osc && reg_wdata[pmc_pkg::SUSP_BIT];
          n.wake_pulse = 1'b1;
        end
      end
      pmc_pkg::PMC_STOP: n.mode = pmc_pkg::PMC_STOP;
      default: n.mode = pmc_pkg::PMC_SEQ;
    endcase

    if (ev.rst_take) begin
      n = pmc_pkg::PMC_RST_VAL;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= pmc_pkg::PMC_RST_VAL;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Read data stands only in the cycle after the strobe.
  assign reg_rdata = r.rdata;
  assign wake_pulse = r.wake_pulse;
  assign boot_addr = pmc_pkg::BOOT_ADDR;

  // CPU control.
  // CPU runs in suspend
  assign cpu_halt = (r.mode == pmc_pkg::PMC_IDLE) || (r.mode == pmc_pkg::PMC_STOP);
  assign cpu_rst = (r.mode == pmc_pkg::PMC_SEQ);

  // Clock gates.
  // idle keeps peripherals clocked
  assign hfosc_en = (r.mode != pmc_pkg::PMC_STOP) && (r.mode != pmc_pkg::PMC_SUSP);
  assign periph_clk_en = hfosc_en;
  assign usb_xcvr_en = (r.mode != pmc_pkg::PMC_STOP);
  assign port_match_en = (r.mode != pmc_pkg::PMC_STOP);
  assign t3_clk_en = hfosc_en || ((r.mode == pmc_pkg::PMC_SUSP) && t3_lowclk);

  assign regulator_en = !((r.mode == pmc_pkg::PMC_STOP) && r.reg_down);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  property p_idle_entry;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_RUN) && instr_done && r.idle_pend && !r.stop_pend
      && !ev.rst_take |=> cpu_halt && periph_clk_en && (r.mode == pmc_pkg::PMC_IDLE);
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("Idle not entered at instruction end.");

  property p_idle_wake;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_IDLE) && irq_pend && !ev.rst_take && !wr_pwr
      |=> !cpu_halt && wake_pulse && !r.idle_pend;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("Interrupt did not end idle.");

  property p_no_early;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_RUN) && !instr_done && !ev.rst_take
      |=> (r.mode == pmc_pkg::PMC_RUN);
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("Mode changed inside an instruction.");

  property p_stop_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_STOP) && !ev.rst_take |=> (r.mode == pmc_pkg::PMC_STOP)
      && !hfosc_en && cpu_halt;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("Stop left without a reset.");

  property p_rst_seq;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(ev.rst_take) |=> cpu_rst [*5];
  endproperty
  a_rst_seq: assert property (p_rst_seq)
    else $error("Reset sequence too short.");

  property p_seq_end;
    @(posedge clk_sys) disable iff (sys_rst)
    $fell(cpu_rst) |-> (r.mode == pmc_pkg::PMC_RUN) && (boot_addr == 16'h0000);
  endproperty
  a_seq_end: assert property (p_seq_end)
    else $error("Reset sequence did not end in run.");

  property p_reg_down;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_STOP) && r.reg_down && !rst_pin
      |-> !regulator_en && !ev.rst_take;
  endproperty
  a_reg_down: assert property (p_reg_down)
    else $error("Internal reset accepted with regulator down.");

  property p_rd_zero;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_rd && (reg_addr == pmc_pkg::PWR_CTRL_ADDR) && !ev.rst_take
      |=> (reg_rdata[1:0] == 2'b00);
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("Mode select bits read nonzero.");

  property p_susp;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_SUSP) |-> !hfosc_en && !cpu_halt && usb_xcvr_en
      && port_match_en && (t3_clk_en == t3_lowclk);
  endproperty
  a_susp: assert property (p_susp)
    else $error("Suspend gating wrong.");

  property p_susp_wake;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_SUSP) && (port_match || usb_resume) && !ev.rst_take
      |=> (r.mode == pmc_pkg::PMC_RUN) && wake_pulse;
  endproperty
  a_susp_wake: assert property (p_susp_wake)
    else $error("Suspend wake event missed.");

  // Modes hold without their exit events; entries and resets act as chosen.
  property p_idle_stay;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_IDLE) && !irq_pend && !ev.rst_take
      |=> (r.mode == pmc_pkg::PMC_IDLE) && cpu_halt && periph_clk_en && usb_xcvr_en;
  endproperty
  a_idle_stay: assert property (p_idle_stay)
    else $error("Idle not held with peripherals running.");

  property p_stop_entry;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_RUN) && instr_done && r.stop_pend && !ev.rst_take
      |=> (r.mode == pmc_pkg::PMC_STOP) && cpu_halt && !periph_clk_en && !t3_clk_en;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("Stop not entered at instruction end.");

  property p_reg_choice;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_RUN) && instr_done && r.stop_pend && !wr_regc && !ev.rst_take
      |=> (regulator_en == !r.regc_bits[pmc_pkg::REGOFF_BIT]);
  endproperty
  a_reg_choice: assert property (p_reg_choice)
    else $error("Regulator state in stop does not follow its option.");

  property p_wdt_idle;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_IDLE) && wdt_rst
      |=> cpu_rst;
  endproperty
  a_wdt_idle: assert property (p_wdt_idle)
    else $error("Watchdog reset did not end idle.");

  property p_mcd_stop;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_STOP) && !r.reg_down && mcd_rst
      |=> cpu_rst;
  endproperty
  a_mcd_stop: assert property (p_mcd_stop)
    else $error("Detector reset did not end stop.");

  property p_susp_stay;
    @(posedge clk_sys) disable iff (sys_rst)
    (r.mode == pmc_pkg::PMC_SUSP) && !port_match && !usb_resume && !(t3_ovf && t3_lowclk)
      && !ev.rst_take |=> (r.mode == pmc_pkg::PMC_SUSP) && !cpu_halt;
  endproperty
  a_susp_stay: assert property (p_susp_stay)
    else $error("Suspend left without a wake event.");

endmodule : pmc_top

`default_nettype wire

/* tb/pmc_cpu_model.sv */
// Purpose: Behavioural CPU that retires instructions and tracks its fetch address.
// Assumes: One instruction ends every fourth clock while the CPU clock runs.
// Notes:   The fetch address restarts at boot_addr while cpu_rst is high.
`timescale 1ns/1ps
`default_nettype none

module pmc_cpu_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Controller side.
  input wire logic cpu_halt,
  input wire logic cpu_rst,
  input wire logic [15:0] boot_addr,
  output logic instr_done,
  output logic [15:0] pc
);
  logic [1:0] phase_reg;

  // multi-cycle instructions
  // Every instruction spans four clocks, so no one-byte opcode follows a mode write.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || cpu_rst) begin
      phase_reg <= 2'h0;
      instr_done <= 1'b0;
      pc <= boot_addr;
    end else begin
      if (!cpu_halt) begin
        phase_reg <= phase_reg + 2'h1;
      end
      instr_done <= !cpu_halt && (phase_reg == 2'h3);
      if (instr_done) begin
        pc <= pc + 16'h0001;
      end
    end
  end
endmodule : pmc_cpu_model

`default_nettype wire

/* tb/pmc_top_bench.sv */
// Purpose: Self-checking bench of the power mode controller.
// Assumes: The CPU model retires instructions; the bench drives all events.
// Notes:   Reads are noted in a queue and checked by a watcher process.
`timescale 1ns/1ps
`default_nettype none

module pmc_top_bench;
  localparam int IRQ = 0, PIN = 1, WDT = 2, MISSING_CLOCK_DETECTOR = 3, SW = 4, PM = 5, T3O = 6, USB = 7;
  logic clk_sys, sys_rst, reg_wr, reg_rd, t3_lowclk, instr_done, cpu_halt, cpu_rst;
  logic wake_pulse, hfosc_en, periph_clk_en, usb_xcvr_en, port_match_en, t3_clk_en;
  logic regulator_en, rd_seen, halt_q, hf_q, done_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ev, gf;
  logic [15:0] boot_addr, pc, pc_s;
  logic [15:0] exp_q[$];
  int errors, cmp_count, cyc, seed;
  int wk[4] = '{PM, T3O, USB, SW};

  pmc_top pmc_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_done(instr_done), .irq_pend(ev[IRQ]), .cpu_halt(cpu_halt), .cpu_rst(cpu_rst),
    .boot_addr(boot_addr), .wake_pulse(wake_pulse), .rst_pin(ev[PIN]), .wdt_rst(ev[WDT]),
    .mcd_rst(ev[MISSING_CLOCK_DETECTOR]), .sw_rst(ev[SW]), .port_match(ev[PM]), .t3_ovf(ev[T3O]),
    .t3_lowclk(t3_lowclk), .usb_resume(ev[USB]), .hfosc_en(hfosc_en),
    .periph_clk_en(periph_clk_en), .usb_xcvr_en(usb_xcvr_en),
    .port_match_en(port_match_en), .t3_clk_en(t3_clk_en), .regulator_en(regulator_en));

  pmc_cpu_model pmc_cpu_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_halt(cpu_halt),
    .cpu_rst(cpu_rst), .boot_addr(boot_addr), .instr_done(instr_done), .pc(pc));

  // Clock of 10 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Ends the run with the verdict.
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({8'h00, e});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  // One-cycle event on a reset or wake input, then a settled look.
  task automatic pulse(input int b);
    @(posedge clk_sys);
    ev[b] <= 1'b1;
    @(posedge clk_sys);
    ev[b] <= 1'b0;
    @(negedge clk_sys);
  endtask : pulse

  task automatic settle(input logic h, input logic f);
    for (int i = 0; i < 40 && !(cpu_halt === h && hfosc_en === f); i++) @(negedge clk_sys);
    chk({cpu_halt, hfosc_en}, {h, f});
  endtask : settle

  // Counts the reset sequence and checks the state it leaves behind.
  task automatic wait_rst(input int n_exp);
    int n;
    n = 0;
    while (cpu_rst === 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
    if (n_exp != 0) chk(16'(n), 16'(n_exp));
    chk({cpu_halt, hfosc_en, regulator_en, usb_xcvr_en}, 4'b0111);
    chk(pc, 16'h0000);
    rd(pmc_pkg::STATUS_ADDR, {5'h00, pmc_pkg::PMC_RUN});
    rd(pmc_pkg::PWR_CTRL_ADDR, 8'h00);
  endtask : wait_rst

  // Takes the oldest noted read result when the read data stand.
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk(16'hFFFF, 16'h0000);
      else chk({8'h00, reg_rdata}, exp_q.pop_front());
    end
  end

  // A mode may only begin right after an instruction has ended.
  always @(posedge clk_sys) begin
    halt_q <= cpu_halt;
    hf_q <= hfosc_en;
    done_q <= instr_done;
    if (!sys_rst && ((cpu_halt && !halt_q) || (!hfosc_en && hf_q)) && !done_q) begin
      errors++;
      $display("[FAIL] %0t mode entered without instruction end", $time);
    end
  end

  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end

  // Main sequence.
  initial begin
    seed = 69174;
    {reg_addr, reg_wdata, reg_wr, reg_rd, ev, t3_lowclk} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wait_rst(0);
    rd(pmc_pkg::OSC_CTRL_ADDR, 8'h00);
    rd(pmc_pkg::REG_CTRL_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    // Idle entered, kept and left by an interrupt.
    gf = 8'($random(seed)) & 8'hFC;
    wr(pmc_pkg::PWR_CTRL_ADDR, gf | 8'h01);
    settle(1'b1, 1'b1);
    chk({periph_clk_en, t3_clk_en, usb_xcvr_en, port_match_en}, 4'hF);
    rd(pmc_pkg::PWR_CTRL_ADDR, gf);
    rd(pmc_pkg::STATUS_ADDR, {5'h00, pmc_pkg::PMC_IDLE});
    pc_s = pc;
    pulse(PM);
    chk(cpu_halt, 1'b1);
    pulse(IRQ);
    chk({cpu_halt, wake_pulse, cpu_rst}, 3'b010);
    chk(pc, pc_s);
    rd(pmc_pkg::STATUS_ADDR, {5'h00, pmc_pkg::PMC_RUN});
    // Watchdog reset ends idle.
    wr(pmc_pkg::PWR_CTRL_ADDR, 8'h01);
    settle(1'b1, 1'b1);
    pulse(WDT);
    wait_rst(5);
    // Stop with the regulator on, ended by the missing clock detector.
    wr(pmc_pkg::PWR_CTRL_ADDR, 8'h02);
    settle(1'b1, 1'b0);
    chk({periph_clk_en, usb_xcvr_en, port_match_en, t3_clk_en, regulator_en}, 5'h01);
    rd(pmc_pkg::PWR_CTRL_ADDR, 8'h00);
    pulse(IRQ);
    pulse(USB);
    chk({cpu_halt, hfosc_en}, 2'b10);
    pulse(MISSING_CLOCK_DETECTOR);
    wait_rst(5);
    // Stop with the regulator off: only the pin resets.
    wr(pmc_pkg::REG_CTRL_ADDR, 8'h01);
    wr(pmc_pkg::PWR_CTRL_ADDR, 8'h02);
    settle(1'b1, 1'b0);
    chk(regulator_en, 1'b0);
    rd(pmc_pkg::STATUS_ADDR, {5'h01, pmc_pkg::PMC_STOP});
    pulse(WDT);
    pulse(MISSING_CLOCK_DETECTOR);
    pulse(SW);
    chk({cpu_halt, cpu_rst, regulator_en}, 3'b100);
    pulse(PIN);
    wait_rst(5);
    rd(pmc_pkg::REG_CTRL_ADDR, 8'h00);
    // Suspend left by each of its wake events, then by a software reset.
    for (int k = 0; k < 4; k++) begin
      t3_lowclk <= (k == 1);
      wr(pmc_pkg::OSC_CTRL_ADDR, 8'h20);
      settle(1'b0, 1'b0);
      chk({periph_clk_en, usb_xcvr_en, port_match_en, t3_clk_en}, {3'b011, k == 1});
      rd(pmc_pkg::OSC_CTRL_ADDR, 8'h20);
      rd(pmc_pkg::STATUS_ADDR, {5'h00, pmc_pkg::PMC_SUSP});
      pc_s = pc;
      pulse(k == 0 ? T3O : IRQ);
      // Leaves room for at least one retired instruction.
      repeat (4) @(negedge clk_sys);
      chk({hfosc_en, pc != pc_s}, 2'b01);
      pulse(wk[k]);
      if (k < 3) begin
        chk({hfosc_en, wake_pulse, cpu_rst, pc == 16'h0000}, 4'b1100);
        rd(pmc_pkg::OSC_CTRL_ADDR, 8'h00);
      end else begin
        wait_rst(5);
      end
    end
    repeat (4) @(posedge clk_sys);
    stop_test();
  end
endmodule : pmc_top_bench

`default_nettype wire
